/* File: muldiv_pkg.sv */
// Constants, enumerations and carrier types of the multiply/divide/shift unit.
// Assumes a 10 MHz APB clock; register indices are word indices on the bus.
package muldiv_pkg;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_OPERAND_BYTE_0 = 8'hf9;
  localparam logic [7:0] IDX_OPERAND_BYTE_5 = 8'hfe;
  localparam logic [7:0] IDX_ARITH_CONTROL_STATUS = 8'hff;
  localparam int ADDR_WORD_LSB = 2;
  localparam int ADDR_IDX_MSB = 9;
  localparam int ADDR_MSB = 11;

  // Control/status field positions and reset value
  localparam int ERR_BIT = 7;
  localparam int OV_BIT = 6;
  localparam int DIR_BIT = 5;
  localparam int SC_MSB = 4;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Byte positions inside the six operand/result registers
  localparam logic [2:0] B0 = 3'h0;
  localparam logic [2:0] B1 = 3'h1;
  localparam logic [2:0] B2 = 3'h2;
  localparam logic [2:0] B3 = 3'h3;
  localparam logic [2:0] B4 = 3'h4;
  localparam logic [2:0] B5 = 3'h5;
  localparam int NUM_BYTES = 6;

  // Latencies in clock cycles from the final loading write
  localparam logic [4:0] LAT_DIV32 = 5'h11;
  localparam logic [4:0] LAT_DIV16 = 5'h09;
  localparam logic [4:0] LAT_MUL = 5'h0a;
  localparam logic [4:0] LAT_SHIFT_BASE = 5'h03;
  localparam logic [31:0] MUL_OV_LIMIT = 32'h0000ffff;
  localparam logic [31:0] DIV0_QUOTIENT = 32'hffffffff;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_BUSY = 2'b10,
    ST_RESULT = 2'b11
  } seq_state_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_DIV32 = 3'b001,
    OP_DIV16 = 3'b010,
    OP_MUL = 3'b011,
    OP_NORM = 3'b100,
    OP_SHIFT = 3'b101
  } op_e;

  // Control/status register as a record
  typedef struct packed {
    logic seq_error_flag;
    logic overflow_flag;
    logic shift_direction;
    logic [4:0] shift_count_field;
  } arith_ctrl_s;

  // One completed APB transfer, as the core sees it
  typedef struct packed {
    logic wr;
    logic rd;
    logic mapped;
    logic [7:0] idx;
    logic [7:0] data;
  } bus_op_s;

endpackage

/* File: op_timer.sv */
// Latency countdown for the multiply/divide/shift unit.
// Assumes load and abort come from the same clock domain and are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

module op_timer
  import muldiv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic load,
  input wire logic abort,
  input wire logic [4:0] load_val,
  output logic last
);

  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;

  ////////////////////////////////////////////////////////////////////////////
  // Count down; last marks the cycle whose edge ends the operation
  always_comb begin
    cnt_next = cnt_reg;
    if (abort) begin
      cnt_next = '0;
    end else if (load) begin
      cnt_next = load_val;
    end else if (cnt_reg != '0) begin
      cnt_next = cnt_reg - 5'h01;
    end
  end

  assign last = (cnt_reg == 5'h01);

  // Frozen while the clock enable is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

endmodule

`default_nettype wire

/* File: muldiv_unit.sv */
// Unsigned multiply, divide, shift and normalize unit with an APB register port.
// Assumes APB3 signalling from a single master; one clock, one async reset.
//
// What this block does
// - Unsigned only: 16x16 multiply, 32-bit divide, 32-bit shift and normalize.
// - No done bit; software waits the fixed latency before reading results.
// - 32/16 divide gives 32-bit quotient, 16-bit remainder, in 17 cycles.
// - 16/16 divide gives 16-bit quotient and remainder in 9 cycles.
// - 16x16 multiply gives a 32-bit product in 10 cycles.
// - Latency counts from final write; normalize 3 to 18, shift 3 to 18.
// - Six byte operand/result registers and one control register.
// - Error flag set when an operand byte is written during an operation.
// - Reading the control register clears the error flag.
// - Overflow flag set on divide with a zero operand.
// - Overflow flag set when a product exceeds 0x0000ffff.
// - Direction bit one shifts right, zero shifts left.
// - Shift count zero starts normalization, removing leading zeros leftward.
// - After normalization the shift count holds the shifts performed.
// - Non-zero shift count starts a shift by that many places.
// - First byte 0 write resets the unit; divisor high byte starts divide.
// - Final result read returns the unit to idle.
// - Overflow flag set when normalizing an operand with top bit one.
`timescale 1ns/1ns
`default_nettype none

module muldiv_unit
  import muldiv_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic busy
);

  ////////////////////////////////////////////////////////////////////////////
  // State
  logic [NUM_BYTES-1:0][7:0] md_reg;
  logic [NUM_BYTES-1:0][7:0] md_next;
  arith_ctrl_s ctrl_reg;
  arith_ctrl_s ctrl_next;
  seq_state_e state_reg;
  seq_state_e state_next;
  op_e op_reg;
  op_e op_next;
  logic [NUM_BYTES-1:0] wr_mask_reg;
  logic [NUM_BYTES-1:0] wr_mask_next;
  logic [2:0] last_wr_reg;
  logic [2:0] last_wr_next;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic busy_reg;
  logic busy_next;

  logic start;
  logic abort;
  logic [4:0] lat;
  logic timer_last;
  bus_op_s bop;
  logic [7:0] rd_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Datapath helpers
  logic [31:0] opnd32;
  logic [31:0] dividend;
  logic [15:0] divisor;
  logic [31:0] quotient;
  logic [15:0] remainder;
  logic [31:0] product;
  logic [31:0] shifted;
  logic [4:0] lead_zeros;

  // Leading zeros of the 32-bit operand; zero operand gives zero
  // Plain scan from the top bit; it folds into a priority encoder
  function automatic logic [4:0] count_lz(input logic [31:0] v);
    logic [4:0] n;
    logic found;
    n = '0;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found && v[i]) begin
        found = 1'b1;
        n = 5'(31 - i);
      end
    end
    return n;
  endfunction

  // The arithmetic settles in one cycle; the timer only delays the write-back
  // so that software sees fixed latencies. This trades area for an exact,
  // simple cycle count.
  // Combinational arithmetic from the held operand bytes
  always_comb begin
    opnd32 = {md_reg[B3], md_reg[B2], md_reg[B1], md_reg[B0]};
    dividend = (op_reg == OP_DIV16) ? {16'h0000, md_reg[B1], md_reg[B0]} : opnd32;
    divisor = {md_reg[B5], md_reg[B4]};
    if (divisor == 16'h0000) begin
      quotient = DIV0_QUOTIENT;
      remainder = dividend[15:0];
    end else begin
      quotient = dividend / {16'h0000, divisor};
      remainder = 16'(dividend % {16'h0000, divisor});
    end
    product = {16'h0000, md_reg[B1], md_reg[B0]} * {16'h0000, md_reg[B5], md_reg[B4]};
    if (ctrl_reg.shift_direction) begin
      shifted = opnd32 >> ctrl_reg.shift_count_field;
    end else begin
      shifted = opnd32 << ctrl_reg.shift_count_field;
    end
    lead_zeros = count_lz(opnd32);
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB decode of the completing access edge
  // Transfers count only on the edge that completes the access
  always_comb begin
    bop.wr = psel & penable & pready_reg & pwrite;
    bop.rd = psel & penable & pready_reg & ~pwrite;
    bop.idx = paddr[ADDR_IDX_MSB:ADDR_WORD_LSB];
    bop.mapped = (paddr[ADDR_MSB:ADDR_IDX_MSB+1] == '0) &&
                 (paddr[ADDR_WORD_LSB-1:0] == '0) &&
                 (paddr[ADDR_IDX_MSB:ADDR_WORD_LSB] >= IDX_OPERAND_BYTE_0);
    bop.data = pwdata[7:0];
  end

  // Read data mux; upper bits read as zero
  // Unmapped indices read as zero and are refused through pslverr
  always_comb begin
    rd_byte = '0;
    if (bop.idx == IDX_ARITH_CONTROL_STATUS) begin
      rd_byte = ctrl_reg;
    end else if (bop.idx >= IDX_OPERAND_BYTE_0 && bop.idx <= IDX_OPERAND_BYTE_5) begin
      rd_byte = md_reg[3'(bop.idx - IDX_OPERAND_BYTE_0)];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus answer: one wait cycle, then pready for one cycle
  // A refused transfer still completes, with pslverr and zero read data
  always_comb begin
    pready_next = psel & penable & ~pready_reg;
    pslverr_next = 1'b0;
    prdata_next = prdata_reg;
    if (pready_next) begin
      pslverr_next = ~bop.mapped;
      prdata_next = (bop.mapped && !pwrite) ? {24'h000000, rd_byte} : '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else if (ce) begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequence control, operand loading and result write-back
  // Idle and result accept new writes alike; the split only marks the
  // window in which the final read closes the sequence.
  always_comb begin
    md_next = md_reg;
    ctrl_next = ctrl_reg;
    state_next = state_reg;
    op_next = op_reg;
    wr_mask_next = wr_mask_reg;
    last_wr_next = last_wr_reg;
    start = 1'b0;
    abort = 1'b0;
    lat = LAT_DIV32;

    // Read side effects first so that a hardware set below wins
    if (bop.rd && bop.mapped) begin
      if (bop.idx == IDX_ARITH_CONTROL_STATUS) begin
        ctrl_next.seq_error_flag = 1'b0;
      end
      if (state_reg == ST_RESULT) begin
        if (((op_reg == OP_DIV32 || op_reg == OP_DIV16) &&
             bop.idx == IDX_OPERAND_BYTE_5) ||
            ((op_reg == OP_MUL || op_reg == OP_NORM || op_reg == OP_SHIFT) &&
             bop.idx == IDX_OPERAND_BYTE_0 + 8'(B3))) begin
          state_next = ST_IDLE;
        end
      end
    end

    // Operand byte writes
    if (bop.wr && bop.mapped && bop.idx <= IDX_OPERAND_BYTE_5) begin
      if (state_reg == ST_BUSY) begin
        ctrl_next.seq_error_flag = 1'b1;
      end
      if (bop.idx == IDX_OPERAND_BYTE_0) begin
        // Byte 0 always (re)opens a load sequence, aborting any operation
        md_next[B0] = bop.data;
        abort = (state_reg == ST_BUSY);
        if (state_reg != ST_LOAD) begin
          state_next = ST_LOAD;
          wr_mask_next = '0;
        end
        wr_mask_next[B0] = 1'b1;
        last_wr_next = B0;
      end else if (state_reg != ST_BUSY) begin
        // Writes during an operation are dropped to protect the result
        md_next[3'(bop.idx - IDX_OPERAND_BYTE_0)] = bop.data;
        wr_mask_next[3'(bop.idx - IDX_OPERAND_BYTE_0)] = 1'b1;
        last_wr_next = 3'(bop.idx - IDX_OPERAND_BYTE_0);
        if (bop.idx == IDX_OPERAND_BYTE_5 && state_reg == ST_LOAD) begin
          start = 1'b1;
          if (last_wr_reg == B1) begin
            op_next = OP_MUL;
            lat = LAT_MUL;
          end else if (wr_mask_reg[B2] && wr_mask_reg[B3]) begin
            op_next = OP_DIV32;
            lat = LAT_DIV32;
          end else begin
            op_next = OP_DIV16;
            lat = LAT_DIV16;
          end
        end
      end
    end

    // Control register write: direction and count, then start
    if (bop.wr && bop.mapped && bop.idx == IDX_ARITH_CONTROL_STATUS &&
        state_reg != ST_BUSY) begin
      ctrl_next.shift_direction = bop.data[DIR_BIT];
      ctrl_next.shift_count_field = bop.data[SC_MSB:0];
      start = 1'b1;
      if (bop.data[SC_MSB:0] == '0) begin
        op_next = OP_NORM;
        lat = LAT_SHIFT_BASE + {1'b0, lead_zeros[4:1]};
      end else begin
        op_next = OP_SHIFT;
        lat = LAT_SHIFT_BASE + {1'b0, bop.data[SC_MSB:1]};
      end
    end

    // Each start clears overflow; normalize checks the top bit now
    if (start) begin
      state_next = ST_BUSY;
      ctrl_next.overflow_flag = (op_next == OP_NORM) && md_reg[B3][7];
    end

    // Write-back on the last latency cycle
    if (state_reg == ST_BUSY && timer_last && !abort) begin
      state_next = ST_RESULT;
      case (op_reg)
        OP_DIV32, OP_DIV16: begin
          md_next[B0] = quotient[7:0];
          md_next[B1] = quotient[15:8];
          md_next[B2] = quotient[23:16];
          md_next[B3] = quotient[31:24];
          md_next[B4] = remainder[7:0];
          md_next[B5] = remainder[15:8];
          if (divisor == 16'h0000 || dividend == '0) begin
            ctrl_next.overflow_flag = 1'b1;
          end
        end
        OP_MUL: begin
          md_next[B0] = product[7:0];
          md_next[B1] = product[15:8];
          md_next[B2] = product[23:16];
          md_next[B3] = product[31:24];
          if (product > MUL_OV_LIMIT) begin
            ctrl_next.overflow_flag = 1'b1;
          end
        end
        OP_NORM: begin
          {md_next[B3], md_next[B2], md_next[B1], md_next[B0]} = opnd32 << lead_zeros;
          ctrl_next.shift_count_field = lead_zeros;
        end
        OP_SHIFT: begin
          {md_next[B3], md_next[B2], md_next[B1], md_next[B0]} = shifted;
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
    // Busy follows the next state, so it rises at the starting edge
    busy_next = (state_next == ST_BUSY);
  end

  // Register the sequence state; all clear at reset
  // A low clock enable holds every field, the timer included
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      md_reg <= {NUM_BYTES{BYTE_RESET}};
      ctrl_reg <= CTRL_RESET;
      state_reg <= ST_IDLE;
      op_reg <= OP_NONE;
      wr_mask_reg <= '0;
      last_wr_reg <= B0;
      busy_reg <= 1'b0;
    end else if (ce) begin
      md_reg <= md_next;
      ctrl_reg <= ctrl_next;
      state_reg <= state_next;
      op_reg <= op_next;
      wr_mask_reg <= wr_mask_next;
      last_wr_reg <= last_wr_next;
      busy_reg <= busy_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Latency timer
  // Loaded by each start and cleared by an abort; its last cycle gates the
  // write-back, so a stale countdown can never store a result.
  op_timer i_op_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .load(start),
    .abort(abort),
    .load_val(lat),
    .last(timer_last)
  );

  // Outputs straight from their registers
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign busy = busy_reg;

endmodule

`default_nettype wire

/* File: muldiv_unit_properties.sv */
// Checker for the bus answer and operation timing of muldiv_unit.
// Assumes it sees only the unit's ports and that ce is low only while the bus is idle.
`timescale 1ns/1ns
`default_nettype none

module muldiv_unit_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic busy
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [4:0] busy_cnt_reg;
  logic [4:0] busy_cnt_next;

  //////////////////////////////
  // Run length of busy; a stuck busy trips the bound before the wrap
  always_comb busy_cnt_next = busy ? busy_cnt_reg + 5'h01 : 5'h00;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) busy_cnt_reg <= 5'h00;
    else busy_cnt_reg <= busy_cnt_next;
  end

  //////////////////////////////
  // Completed transfers
  sequence ctrl_rd;
    psel && penable && pready && !pwrite && paddr == 12'h3fc;
  endsequence
  sequence taken_wr;
    psel && penable && pready && pwrite;
  endsequence

  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  ready_delay_a: assert property (psel && penable && !pready |=> pready)
    else $error("ready late after access cycle");
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("ready outside an access");
  slverr_data_a: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused transfer returned data");
  misaligned_err_a: assert property (pready && paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned address accepted");
  mapped_ok_a: assert property (pready && paddr[1:0] == 2'b00 &&
    paddr[11:2] inside {[10'h0f9:10'h0ff]} |-> !pslverr)
    else $error("mapped register refused");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("read data upper lanes not zero");
  err_clear_a: assert property (ctrl_rd ##[1:4] ctrl_rd |-> !prdata[7])
    else $error("error flag survived a control read");
  busy_cause_a: assert property ($rose(busy) |-> $past(psel && penable && pready && pwrite))
    else $error("busy rose without a write");
  busy_bound_a: assert property (busy_cnt_reg <= 5'd20)
    else $error("operation longer than twenty cycles");
  reset_quiet_a: assert property ($rose(presetn) |-> !pready && !busy)
    else $error("outputs active after reset");
  cover_write: cover property (taken_wr ##1 busy);
endmodule

bind muldiv_unit muldiv_unit_checker i_muldiv_unit_checker (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .busy(busy)
);
`default_nettype wire

/* File: cpu_bus_model.sv */
// Bus master standing in for the processor core in front of the unit.
// Assumes one clock; requests are held until pready is sampled high.
`timescale 1ns/1ns
`default_nettype none

module cpu_bus_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Idle bus at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  //////////////////////////////
  // One transfer; always leaves an idle edge so no signal is set twice
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [7:0] d,
    output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~pwdata;
  endtask
endmodule
`default_nettype wire

/* File: tb_muldiv_unit.sv */
// Self-checking bench for muldiv_unit, driven through the bus model.
// Assumes a 10 MHz clock and ce low only while the bus is idle; waits follow latencies.
`timescale 1ns/1ns
`default_nettype none

`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end

module tb_muldiv_unit;
  import muldiv_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel, penable, pwrite, pready, pslverr, busy;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic e;
  int err_count = 0;
  int cmp_count = 0;
  int cycles = 0;

  muldiv_unit i_muldiv_unit (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .busy(busy));
  cpu_bus_model i_cpu_bus_model (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    forever #50 pclk = ~pclk;
  end

  // Hang guard; a full run needs well under two thousand cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      end_of_test();
    end
  end

  //////////////////////////////
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    i_cpu_bus_model.xfer(1'b1, {2'b00, i, 2'b00}, d, q, e);
  endtask

  task automatic rd(input logic [7:0] i, input logic [7:0] x, input logic [7:0] m);
    i_cpu_bus_model.xfer(1'b0, {2'b00, i, 2'b00}, 8'h00, q, e);
    `CHK($sformatf("reg %h", i), {24'h0, x & m}, q & {24'h0, m})
    `CHK("slverr", 1'b0, e)
  endtask

  // Busy must still stand one edge before write-back and be gone at it
  task automatic lat(input int n);
    repeat (n - 1) @(posedge pclk);
    #1 `CHK("busy", 1'b1, busy)
    @(posedge pclk);
    #1 `CHK("done", 1'b0, busy)
  endtask

  task automatic ldw(input logic [31:0] v);
    for (int k = 0; k < 4; k++) wr(IDX_OPERAND_BYTE_0 + 8'(k), v[8*k +: 8]);
  endtask

  task automatic chkw(input logic [47:0] v, input int nb, input logic [7:0] m);
    for (int k = 0; k < nb; k++) rd(IDX_OPERAND_BYTE_0 + 8'(k), v[8*k +: 8], m);
  endtask

  //////////////////////////////
  task automatic mul(input logic [15:0] a, input logic [15:0] b);
    logic [31:0] p;
    p = {16'h0, a} * {16'h0, b};
    wr(8'hf9, a[7:0]);
    wr(8'hfd, b[7:0]);
    wr(8'hfa, a[15:8]);
    wr(8'hfe, b[15:8]);
    lat(10);
    chkw({16'h0, p}, 4, 8'hff);
    rd(IDX_ARITH_CONTROL_STATUS, {1'b0, p > MUL_OV_LIMIT, 6'h0}, 8'hc0);
    $display("test multiply done");
  endtask

  task automatic div(input logic [31:0] n, input logic [15:0] d, input bit big);
    logic [31:0] qt;
    logic [15:0] r;
    qt = (d != 0) ? n / {16'h0, d} : DIV0_QUOTIENT;
    r = (d != 0) ? 16'(n % {16'h0, d}) : n[15:0];
    wr(8'hf9, n[7:0]);
    wr(8'hfa, n[15:8]);
    if (big) ldw(n);
    wr(8'hfd, d[7:0]);
    wr(8'hfe, d[15:8]);
    lat(big ? 17 : 9);
    chkw({r, qt}, 6, 8'hff);
    rd(IDX_ARITH_CONTROL_STATUS, {1'b0, d == 0 || n == 0, 6'h0}, 8'h40);
    $display("test divide done");
  endtask

  task automatic sh(input logic [31:0] v, input logic [7:0] c, input logic [31:0] r,
    input int n, input logic [7:0] x, input logic [7:0] m);
    ldw(v);
    wr(IDX_ARITH_CONTROL_STATUS, c);
    lat(n);
    chkw({16'h0, r}, 4, 8'hff);
    rd(IDX_ARITH_CONTROL_STATUS, x, m);
    $display("test shift done");
  endtask

  //////////////////////////////
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (int k = 0; k < 7; k++) rd(IDX_OPERAND_BYTE_0 + 8'(k), 8'h00, 8'hff);
    i_cpu_bus_model.xfer(1'b0, 12'h3e0, 8'h00, q, e);
    `CHK("unmapped", 1'b1, e)
    i_cpu_bus_model.xfer(1'b1, 12'h3fd, 8'h55, q, e);
    `CHK("misaligned", 1'b1, e)
    $display("test reset and map done");
    mul(16'h1234, 16'h5678);
    mul(16'h00ff, 16'h0101);
    div(32'h12345678, 16'h0100, 1'b1);
    div(32'h00001234, 16'h0010, 1'b0);
    div(32'h00000005, 16'h0000, 1'b0);
    sh(32'h80000001, 8'h24, 32'h08000000, 5, 8'h00, 8'hc0);
    sh(32'h80000001, 8'h1f, 32'h80000000, 18, 8'h00, 8'hc0);
    sh(32'h00012345, 8'h00, 32'h91a28000, 10, 8'h0f, 8'hff);
    sh(32'h80000000, 8'h00, 32'h80000000, 3, 8'h40, 8'hff);
    // A low clock enable freezes a multiply, so it ends four edges later
    wr(8'hf9, 8'h07);
    wr(8'hfd, 8'h09);
    wr(8'hfa, 8'h00);
    wr(8'hfe, 8'h00);
    ce <= 1'b0;
    repeat (4) @(posedge pclk);
    ce <= 1'b1;
    lat(10);
    chkw(48'h3f, 4, 8'hff);
    $display("test clock enable done");
    // Write during multiply is dropped, flagged, then cleared by a read
    wr(8'hf9, 8'h02);
    wr(8'hfd, 8'h03);
    wr(8'hfa, 8'h00);
    wr(8'hfe, 8'h00);
    wr(8'hfa, 8'h55);
    rd(IDX_ARITH_CONTROL_STATUS, 8'h80, 8'h80);
    rd(IDX_ARITH_CONTROL_STATUS, 8'h00, 8'h80);
    repeat (4) @(posedge pclk);
    chkw(48'h6, 4, 8'hff);
    // Byte 0 write aborts a long shift and the unit still divides
    ldw(32'hffffffff);
    wr(IDX_ARITH_CONTROL_STATUS, 8'h1f);
    wr(8'hf9, 8'h00);
    #1 `CHK("abort", 1'b0, busy)
    rd(IDX_ARITH_CONTROL_STATUS, 8'h80, 8'h80);
    div(32'h0000ffff, 16'h0003, 1'b0);
    $display("test error flag done");
    end_of_test();
  end
endmodule
`default_nettype wire
